// [logic/flag_fifo.sv]
// Dual-clock flag FIFO core with sampled link clocks and register port
`timescale 1ns/100ps
module flag_fifo (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wclk_i,
  input wire logic write_en_n_i,
  input wire logic [flag_fifo_pkg::DATA_W-1:0] wdata_i,
  input wire logic rclk_i,
  input wire logic read_en_n_i,
  input wire logic read_select_n_i,
  input wire logic retransmit_req_n_i,
  input wire logic mark_i,
  output logic [flag_fifo_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_oe_o,
  output logic empty_indicator_n_o,
  output logic out_word_valid_n_o,
  output logic in_space_avail_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);

  //------------------------------------------------------------
  // Pin sampling
  //------------------------------------------------------------
  logic [flag_fifo_pkg::PIN_W-1:0] pin_raw; // All link-side pins
  logic [flag_fifo_pkg::PIN_W-1:0] sync1; // Metastability catcher
  logic [flag_fifo_pkg::PIN_W-1:0] sync2; // Settled sample
  logic [flag_fifo_pkg::PIN_W-1:0] sync3; // One older, for edges/data

  assign pin_raw = {mark_i, retransmit_req_n_i, read_select_n_i, read_en_n_i,
                    rclk_i, wdata_i, write_en_n_i, wclk_i};

  // Two flops before use; the third gives edges and pre-edge data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= flag_fifo_pkg::SYNC_RST;
      sync2 <= flag_fifo_pkg::SYNC_RST;
      sync3 <= flag_fifo_pkg::SYNC_RST;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic wclk_rise; // Write clock edge seen
  logic rclk_rise; // Read clock edge seen
  logic rd_req; // Read enable and select both active
  logic rt_req; // Retransmit request active
  // Data comes from sync3, the sample before the edge, so late changes never leak in
  assign wclk_rise = sync2[flag_fifo_pkg::PIN_WCLK] & ~sync3[flag_fifo_pkg::PIN_WCLK];
  assign rclk_rise = sync2[flag_fifo_pkg::PIN_RCLK] & ~sync3[flag_fifo_pkg::PIN_RCLK];
  assign rd_req = ~sync3[flag_fifo_pkg::PIN_REN] & ~sync3[flag_fifo_pkg::PIN_RCS];
  assign rt_req = ~sync3[flag_fifo_pkg::PIN_RT];

  //------------------------------------------------------------
  // Software registers
  //------------------------------------------------------------
  logic fall_through_mode; // Fall-through mode select
  logic [flag_fifo_pkg::OFFS_W-1:0] ae_offs; // Almost-empty offset
  logic [flag_fifo_pkg::OFFS_W-1:0] af_offs; // Almost-full offset
  logic [flag_fifo_pkg::EV_W-1:0] irq_en; // Interrupt enables
  logic [flag_fifo_pkg::EV_W-1:0] irq_stat; // Sticky events
  logic [flag_fifo_pkg::EV_W-1:0] irq_clr; // Clear strobe bits
  logic [flag_fifo_pkg::EV_W-1:0] ev; // Event pulses

  // Mode change is only safe while the FIFO is empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fall_through_mode <= 1'b0;
      ae_offs <= flag_fifo_pkg::AE_OFFS_RST;
      af_offs <= flag_fifo_pkg::AF_OFFS_RST;
      irq_en <= flag_fifo_pkg::EV_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        flag_fifo_pkg::REG_CTRL: fall_through_mode <= reg_wdata_i[0];
        flag_fifo_pkg::REG_AE_OFFS: ae_offs <= reg_wdata_i[flag_fifo_pkg::OFFS_W-1:0];
        flag_fifo_pkg::REG_AF_OFFS: af_offs <= reg_wdata_i[flag_fifo_pkg::OFFS_W-1:0];
        flag_fifo_pkg::REG_IRQ_EN: irq_en <= reg_wdata_i[flag_fifo_pkg::EV_W-1:0];
        default: ; // Other offsets hold no writable state
      endcase
    end
  end

  assign irq_clr = (reg_wr_i && reg_addr_i == flag_fifo_pkg::REG_IRQ_CLR) ?
                   reg_wdata_i[flag_fifo_pkg::EV_W-1:0] : flag_fifo_pkg::EV_RST;

  // Sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= flag_fifo_pkg::EV_RST;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | ev;
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  //------------------------------------------------------------
  // Write side
  //------------------------------------------------------------
  logic [flag_fifo_pkg::DATA_W-1:0] mem [0:2047]; // Word storage
  logic [flag_fifo_pkg::PTR_W-1:0] wptr; // Write pointer, binary
  logic [flag_fifo_pkg::PTR_W-1:0] wgray; // Write pointer, gray
  logic [flag_fifo_pkg::PTR_W-1:0] wq1; // Guard sync stage 1
  logic [flag_fifo_pkg::PTR_W-1:0] wq2; // Guard sync stage 2
  logic [flag_fifo_pkg::PTR_W-1:0] wguard; // Guard pointer, binary
  logic [flag_fifo_pkg::PTR_W-1:0] fill_w; // Fill seen by writer
  logic full_w; // No room for a write
  logic wr_go; // Accepted write
  logic [flag_fifo_pkg::PTR_W-1:0] rgray; // Read guard, gray

  assign wguard = flag_fifo_pkg::gray2bin(wq2);
  // Guard is the mark while one is set, so writes stop there
  assign fill_w = wptr - wguard;
  // Memory holds DEPTH; fall-through adds the output word on top
  assign full_w = (fill_w >= flag_fifo_pkg::DEPTH);
  assign wr_go = wclk_rise & ~sync3[flag_fifo_pkg::PIN_WEN] & ~full_w;

  // Advance write pointer on an accepted write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= flag_fifo_pkg::PTR_RST;
      wgray <= flag_fifo_pkg::PTR_RST;
    end else if (wr_go) begin
      wptr <= wptr + flag_fifo_pkg::PTR_ONE;
      wgray <= flag_fifo_pkg::bin2gray(wptr + flag_fifo_pkg::PTR_ONE);
    end
  end

  // Storage write; no reset, contents undefined until written
  always_ff @(posedge clk_i) begin
    if (wr_go) begin
      mem[wptr[flag_fifo_pkg::ADDR_W-1:0]] <= sync3[flag_fifo_pkg::PIN_WD +: flag_fifo_pkg::DATA_W];
    end
  end

  // Read guard crosses into write timing on write clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wq1 <= flag_fifo_pkg::PTR_RST;
      wq2 <= flag_fifo_pkg::PTR_RST;
    end else if (wclk_rise) begin
      wq1 <= rgray;
      wq2 <= wq1;
    end
  end

  //------------------------------------------------------------
  // Read side
  //------------------------------------------------------------
  logic [flag_fifo_pkg::PTR_W-1:0] rptr; // Read pointer, binary
  logic [flag_fifo_pkg::PTR_W-1:0] rq1; // Write ptr sync stage 1
  logic [flag_fifo_pkg::PTR_W-1:0] rq2; // Write ptr sync stage 2
  logic [flag_fifo_pkg::PTR_W-1:0] avail; // Words in storage
  logic [flag_fifo_pkg::PTR_W-1:0] fill_r; // Fill incl. output word
  logic [flag_fifo_pkg::PTR_W-1:0] mark_ptr; // Marked location
  logic [flag_fifo_pkg::DATA_W-1:0] rdata_q; // Output register
  logic out_valid; // Output register holds a word
  logic mark_set; // Mark is active
  logic has_data; // Storage not empty
  logic rt_idle; // No retransmit in progress
  logic rt_start; // Retransmit begins
  logic mem_pop; // Word moves to output register
  flag_fifo_pkg::rt_state_t rt_state; // Retransmit sequencer

  assign avail = flag_fifo_pkg::gray2bin(rq2) - rptr;
  assign has_data = (avail != flag_fifo_pkg::PTR_RST);
  assign fill_r = avail + {{(flag_fifo_pkg::PTR_W-1){1'b0}}, fall_through_mode & out_valid};
  assign rt_idle = (rt_state == flag_fifo_pkg::RT_IDLE);
  // Retransmit wins over a read; reader keeps them apart
  assign rt_start = rclk_rise & rt_idle & rt_req & mark_set;
  // In fall-through an empty output register loads by itself; all other pops need both
  assign mem_pop = rclk_rise & rt_idle & ~rt_start & has_data &
                   (fall_through_mode ? (~out_valid | rd_req) : rd_req);

  // Write pointer crosses into read timing on read clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rq1 <= flag_fifo_pkg::PTR_RST;
      rq2 <= flag_fifo_pkg::PTR_RST;
      rgray <= flag_fifo_pkg::PTR_RST;
    end else if (rclk_rise) begin
      rq1 <= wgray;
      rq2 <= rq1;
      rgray <= flag_fifo_pkg::bin2gray(mark_set ? mark_ptr : rptr);
    end
  end

  // Read pointer, output register and its valid bit.
  // An enable that meets select too early pops the fallen word
  // before the bus is driven, so the second word is shown.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rptr <= flag_fifo_pkg::PTR_RST;
      rdata_q <= flag_fifo_pkg::DATA_RST;
      out_valid <= 1'b0;
    end else if (rt_start) begin
      rptr <= mark_ptr;
      out_valid <= 1'b0;
    end else if (mem_pop) begin
      rptr <= rptr + flag_fifo_pkg::PTR_ONE;
      rdata_q <= mem[rptr[flag_fifo_pkg::ADDR_W-1:0]];
      out_valid <= fall_through_mode;
    end else if (rclk_rise && rt_idle && fall_through_mode && rd_req) begin
      out_valid <= 1'b0; // Last word taken, nothing behind it
    end
  end

  // Mark follows the mark pin; it points at the word on show, or else at the next word to read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mark_set <= 1'b0;
      mark_ptr <= flag_fifo_pkg::PTR_RST;
    end else if (rclk_rise && rt_idle) begin
      if (sync3[flag_fifo_pkg::PIN_MARK] && !mark_set) begin
        mark_set <= 1'b1;
        mark_ptr <= (fall_through_mode && out_valid) ? rptr - flag_fifo_pkg::PTR_ONE : rptr;
      end else if (!sync3[flag_fifo_pkg::PIN_MARK]) begin
        mark_set <= 1'b0;
      end
    end
  end

  // Retransmit: hold while requested, one setup edge, then idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_state <= flag_fifo_pkg::RT_IDLE;
    end else begin
      unique case (rt_state)
        flag_fifo_pkg::RT_IDLE: begin
          if (rt_start) begin
            rt_state <= flag_fifo_pkg::RT_HOLD;
          end
        end
        flag_fifo_pkg::RT_HOLD: begin
          if (rclk_rise && !rt_req) begin
            rt_state <= flag_fifo_pkg::RT_LOAD;
          end
        end
        flag_fifo_pkg::RT_LOAD: begin
          if (rclk_rise) begin
            rt_state <= flag_fifo_pkg::RT_IDLE;
          end
        end
        default: rt_state <= flag_fifo_pkg::RT_IDLE; // Unused code 10
      endcase
    end
  end

  //------------------------------------------------------------
  // Flags and events
  //------------------------------------------------------------
  // Registered from synchronised pointers; a missed skew shows as
  // one extra far-side clock before the flag changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      empty_indicator_n_o <= 1'b0;
      out_word_valid_n_o <= 1'b1;
      in_space_avail_n_o <= 1'b0;
      almost_empty_flag_n_o <= 1'b0;
      almost_full_flag_n_o <= 1'b1;
    end else begin
      empty_indicator_n_o <= ~fall_through_mode & rt_idle & has_data;
      out_word_valid_n_o <= ~(fall_through_mode & out_valid);
      in_space_avail_n_o <= full_w;
      // Fill counts from the restored pointer, so it may move early
      almost_empty_flag_n_o <= ~(fill_r <= {1'b0, ae_offs});
      almost_full_flag_n_o <= ~(fill_w >= flag_fifo_pkg::DEPTH - {1'b0, af_offs});
    end
  end

  assign rdata_o = rdata_q;
  // Bus driven while select is low; enable should trail it
  assign rdata_oe_o = ~sync3[flag_fifo_pkg::PIN_RCS];

  // Bit 0 overflow, 1 underflow, 2 retransmit done, 3 became full
  assign ev[0] = wclk_rise & ~sync3[flag_fifo_pkg::PIN_WEN] & full_w;
  assign ev[1] = rclk_rise & rt_idle & rd_req & ~has_data & ~(fall_through_mode & out_valid);
  assign ev[2] = rclk_rise & (rt_state == flag_fifo_pkg::RT_LOAD);
  assign ev[3] = full_w & ~in_space_avail_n_o;

  //------------------------------------------------------------
  // Register read port
  //------------------------------------------------------------
  logic [31:0] rd_mux; // Selected read value

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr_i)
      flag_fifo_pkg::REG_CTRL: rd_mux[0] = fall_through_mode;
      flag_fifo_pkg::REG_AE_OFFS: rd_mux[flag_fifo_pkg::OFFS_W-1:0] = ae_offs;
      flag_fifo_pkg::REG_AF_OFFS: rd_mux[flag_fifo_pkg::OFFS_W-1:0] = af_offs;
      flag_fifo_pkg::REG_STATUS: rd_mux[flag_fifo_pkg::ST_W-1:0] = {~rt_idle, mark_set,
        almost_full_flag_n_o, almost_empty_flag_n_o, in_space_avail_n_o,
        out_word_valid_n_o, empty_indicator_n_o};
      flag_fifo_pkg::REG_IRQ_STAT: rd_mux[flag_fifo_pkg::EV_W-1:0] = irq_stat;
      flag_fifo_pkg::REG_IRQ_EN: rd_mux[flag_fifo_pkg::EV_W-1:0] = irq_en;
      flag_fifo_pkg::REG_FILL: rd_mux[flag_fifo_pkg::PTR_W-1:0] = fill_r;
      default: rd_mux = 32'h0000_0000; // Unmapped and clear read as zero
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_EF_RELEASE: assert property (
    (!fall_through_mode && wr_go && !has_data && rt_idle && !mark_set) |-> ##[1:60] empty_indicator_n_o)
    else $error("empty indicator not released after write");

  AST_OR_ASSERT: assert property (
    (fall_through_mode && wr_go && !has_data && !out_valid && rt_idle && !mark_set)
      |-> ##[1:60] !out_word_valid_n_o)
    else $error("output valid not shown after first write");

  AST_IR_RETURN: assert property (
    (fall_through_mode && full_w && mem_pop && !mark_set) |-> ##[1:60] !in_space_avail_n_o)
    else $error("input space not returned after read");

  AST_PAE_CLEAR: assert property (
    (fill_r > {1'b0, ae_offs}) |=> almost_empty_flag_n_o)
    else $error("almost empty still set above offset");

  AST_PAF_CLEAR: assert property (
    (fill_w < flag_fifo_pkg::DEPTH - {1'b0, af_offs}) |=> almost_full_flag_n_o)
    else $error("almost full still set below threshold");

  AST_FIRST_FALL: assert property (
    (fall_through_mode && rclk_rise && rt_idle && !rt_req && !out_valid && has_data)
      |=> out_valid && rptr == $past(rptr) + flag_fifo_pkg::PTR_ONE)
    else $error("first word did not fall through");

  AST_PTR_HOLD: assert property (
    (fall_through_mode && rclk_rise && out_valid && !rd_req && !rt_req) |=> $stable(rptr))
    else $error("read pointer moved without enable and select");

  AST_MARK_GUARD: assert property (
    wr_go |-> (fill_w < flag_fifo_pkg::DEPTH))
    else $error("write passed the guard location");

  AST_RT_SETUP: assert property (
    (!rt_idle && $past(!rt_idle)) |-> (!empty_indicator_n_o && out_word_valid_n_o))
    else $error("retransmit setup not shown on flags");

  CVR_FIRST_WRITE: cover property (wr_go && !has_data);
  CVR_FULL: cover property (ev[3]);
  CVR_RT_DONE: cover property (ev[2]);
  CVR_FT_POP: cover property (fall_through_mode && mem_pop && out_valid);

endmodule : flag_fifo

// [logic/flag_fifo_pkg.sv]
// Constants, register map and types for the dual-clock flag FIFO
//------------------------------------------------------------
// Notes on behaviour
// - Standard mode: empty released after pointer sync
// - Fall-through: output valid follows first write
// - Fall-through: input space returns after read
// - Almost-empty clears once fill exceeds offset
// - Almost-full clears once fill drops below
// - Fall-through holds depth plus output word
// - Early read enable loses first word unseen
// - First word falls through without enables
// - Later pops need enable and select both
// - Write pointer never passes marked location
// - Retransmit done shown by empty or valid
// - Almost-empty may move one cycle early
// - Flag offsets are eleven bits wide here
//------------------------------------------------------------
package flag_fifo_pkg;

  // Datapath geometry: smallest depth, 18-bit ports
  localparam int DATA_W = 18;
  localparam int ADDR_W = 11;
  localparam int PTR_W = 12;
  localparam logic [PTR_W-1:0] DEPTH = 12'h0800;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h0000;
  localparam logic [PTR_W-1:0] PTR_ONE = 12'h0001;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
  localparam int OFFS_W = 11;

  // Positions of the pin inputs in the sampled vector
  localparam int PIN_WCLK = 0;
  localparam int PIN_WEN = 1;
  localparam int PIN_WD = 2;
  localparam int PIN_RCLK = 20;
  localparam int PIN_REN = 21;
  localparam int PIN_RCS = 22;
  localparam int PIN_RT = 23;
  localparam int PIN_MARK = 24;
  localparam int PIN_W = 25;
  localparam logic [PIN_W-1:0] SYNC_RST = 25'h0ff_ffff; // Idle levels, mark low

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AE_OFFS = 8'h04;
  localparam logic [7:0] REG_AF_OFFS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN = 8'h18;
  localparam logic [7:0] REG_FILL = 8'h1c;

  // Reset values of software state
  localparam logic [OFFS_W-1:0] AE_OFFS_RST = 11'h007;
  localparam logic [OFFS_W-1:0] AF_OFFS_RST = 11'h007;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam int ST_W = 7;

  // Retransmit sequencer, gray along idle-hold-load
  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_HOLD = 2'b01,
    RT_LOAD = 2'b11
  } rt_state_t;

  // Gray conversion for pointers that cross between clock domains
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

endpackage : flag_fifo_pkg

// [bench/fifo_link_model.sv]
// Writer-side partner: free-running link clocks and a counted word source
`timescale 1ns/100ps
module fifo_link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wr_target_i,
  output logic wclk_o,
  output logic rclk_o,
  output logic write_en_n_o,
  output logic [17:0] wdata_o,
  output logic [31:0] wr_cnt_o
);
  logic wclk_q; // Previous writer clock sample
  logic [31:0] next_cnt; // Word count once the pending write has landed
  logic go; // More words still wanted
  // ----------------------------------------
  // Link clocks, 125 ns, unrelated phases
  // ----------------------------------------
  initial begin
    wclk_o = 1'b0;
    #17;
    forever #62.5 wclk_o = ~wclk_o;
  end
  initial begin
    rclk_o = 1'b0;
    #71.3;
    forever #62.5 rclk_o = ~rclk_o;
  end
  assign next_cnt = wr_cnt_o + {31'h0, ~write_en_n_o};
  assign go = next_cnt < wr_target_i;
  // Pins move at a writer clock fall, far from the rise that takes them;
  // idle data is inverted so a stale word never passes for a real one
  always_ff @(posedge clk_i) begin
    wclk_q <= wclk_o;
    if (rst_i) begin
      write_en_n_o <= 1'b1;
      wr_cnt_o <= 32'h0000_0000;
      wdata_o <= 18'h2_0000;
    end else if (wclk_q && !wclk_o) begin
      wr_cnt_o <= next_cnt;
      write_en_n_o <= !go;
      wdata_o <= go ? {1'b1, next_cnt[16:0]} : ~{1'b1, next_cnt[16:0]};
    end
  end
endmodule : fifo_link_model

// [bench/dual_clock_fifo_flags_retransmit_test.sv]
// Self-checking bench for the dual-clock flag FIFO
`timescale 1ns/100ps
module dual_clock_fifo_flags_retransmit_test;
  logic clk_i, rst_i; // System clock and reset
  logic wclk, rclk, write_en_n; // From the writer partner
  logic read_en_n, read_select_n, retransmit_req_n, mark; // Reader pins
  logic rdata_oe, empty_n, valid_n, space_n, ae_n, af_n, irq; // Flags
  logic [17:0] wdata, rdata; // Word buses
  logic [3:0] flags; // Waitable flags: 0 empty, 1 valid, 2 space, 3 almost empty
  assign flags = {ae_n, space_n, valid_n, empty_n};
  logic [7:0] reg_addr; // Register port address
  logic [31:0] reg_wdata, reg_rdata, wr_target, wr_cnt;
  logic reg_wr, reg_rd; // Register strobes
  int errors, comparisons;
  int cycles = 0; // Hang guard
  fifo_link_model writer (.clk_i(clk_i), .rst_i(rst_i), .wr_target_i(wr_target),
    .wclk_o(wclk), .rclk_o(rclk), .write_en_n_o(write_en_n), .wdata_o(wdata),
    .wr_cnt_o(wr_cnt));
  flag_fifo uut (.clk_i(clk_i), .rst_i(rst_i), .wclk_i(wclk), .write_en_n_i(write_en_n),
    .wdata_i(wdata), .rclk_i(rclk), .read_en_n_i(read_en_n),
    .read_select_n_i(read_select_n), .retransmit_req_n_i(retransmit_req_n), .mark_i(mark),
    .rdata_o(rdata), .rdata_oe_o(rdata_oe), .empty_indicator_n_o(empty_n),
    .out_word_valid_n_o(valid_n), .in_space_avail_n_o(space_n),
    .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // A full fill and drain take about 52k cycles; beyond 70k it is a hang
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 70000) begin
      errors++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  function automatic logic [17:0] word_at(input int i);
    return {1'b1, i[16:0]};
  endfunction : word_at
  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask : check_bit
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Bounded wait for a flag, sampled mid-cycle where it has settled
  task automatic wait_level(input int idx, input logic val, input int limit, input string what);
    int n;
    n = 0;
    while (flags[idx] !== val && n < limit) begin
      @(negedge clk_i);
      n++;
    end
    check_bit(flags[idx], val, what);
  endtask : wait_level
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    @(negedge clk_i);
    check_word(reg_rdata, exp, "register read");
  endtask : reg_read
  // Reader pins change just after a reader clock fall, away from its rise
  task automatic rfall;
    @(negedge rclk);
    @(negedge clk_i);
  endtask : rfall
  task automatic set_reader(input logic sel_n, input logic en_n);
    @(posedge clk_i);
    read_select_n <= sel_n;
    read_en_n <= en_n;
  endtask : set_reader
  task automatic push_words(input int n);
    logic [31:0] tgt;
    int k;
    tgt = wr_cnt + n;
    k = 0;
    @(posedge clk_i);
    wr_target <= tgt;
    while (wr_cnt !== tgt && k < 14 * n + 40) begin
      @(negedge clk_i);
      k++;
    end
    check_word(wr_cnt, tgt, "words written");
  endtask : push_words
  task automatic std_read(input int n, input int first);
    rfall();
    set_reader(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      rfall();
      check_word({14'h0, rdata}, {14'h0, word_at(first + i)}, "read word");
    end
    set_reader(1'b1, 1'b1);
  endtask : std_read
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_registers_irq;
    reg_read(flag_fifo_pkg::REG_STATUS, 32'h0000_0012);
    reg_read(flag_fifo_pkg::REG_AF_OFFS, 32'h0000_0007);
    reg_read(8'h20, 32'h0000_0000);
    reg_read(flag_fifo_pkg::REG_IRQ_CLR, 32'h0000_0000);
    reg_write(flag_fifo_pkg::REG_AE_OFFS, 32'h0000_ffff);
    reg_read(flag_fifo_pkg::REG_AE_OFFS, 32'h0000_07ff);
    reg_write(flag_fifo_pkg::REG_AE_OFFS, 32'h0000_0007);
    rfall();
    set_reader(1'b0, 1'b0);
    rfall();
    set_reader(1'b1, 1'b1);
    reg_read(flag_fifo_pkg::REG_IRQ_STAT, 32'h0000_0002);
    check_bit(irq, 1'b0, "masked interrupt");
    reg_write(flag_fifo_pkg::REG_IRQ_EN, 32'h0000_0002);
    @(negedge clk_i);
    check_bit(irq, 1'b1, "enabled interrupt");
    reg_write(flag_fifo_pkg::REG_IRQ_CLR, 32'h0000_0002);
    @(negedge clk_i);
    check_bit(irq, 1'b0, "cleared interrupt");
  endtask : test_registers_irq
  task automatic test_standard;
    push_words(1);
    check_bit(empty_n, 1'b0, "empty held at write");
    wait_level(0, 1'b1, 48, "empty released");
    push_words(6);
    repeat (48) @(negedge clk_i);
    check_bit(ae_n, 1'b0, "almost empty at offset");
    push_words(1);
    wait_level(3, 1'b1, 48, "almost empty cleared");
    push_words(12);
  endtask : test_standard
  // Twenty words stored, above the sixteen a mark needs
  task automatic test_retransmit;
    @(posedge clk_i);
    mark <= 1'b1;
    rfall();
    rfall();
    std_read(3, 0);
    rfall();
    @(posedge clk_i);
    retransmit_req_n <= 1'b0;
    rfall();
    check_bit(empty_n, 1'b0, "empty during setup");
    @(posedge clk_i);
    retransmit_req_n <= 1'b1;
    wait_level(0, 1'b1, 48, "setup complete");
    std_read(20, 0);
    wait_level(0, 1'b0, 20, "empty after replay");
    @(posedge clk_i);
    mark <= 1'b0;
  endtask : test_retransmit
  task automatic test_fall_through;
    int n;
    reg_write(flag_fifo_pkg::REG_CTRL, 32'h0000_0001);
    @(posedge clk_i);
    wr_target <= wr_cnt + 32'h0000_0834;
    wait_level(1, 1'b0, 80, "first word fell through");
    wait_level(2, 1'b1, 28000, "buffer full");
    // Keep writing past full so the overflow event is certain
    repeat (30) @(posedge clk_i);
    wr_target <= wr_cnt;
    repeat (40) @(negedge clk_i);
    check_bit(af_n, 1'b0, "almost full");
    reg_read(flag_fifo_pkg::REG_IRQ_STAT, 32'h0000_000d);
    rfall();
    set_reader(1'b0, 1'b1);
    rfall();
    check_bit(rdata_oe, 1'b1, "output driven");
    set_reader(1'b0, 1'b0);
    n = 0;
    while (valid_n === 1'b0 && n < 2100) begin
      check_word({14'h0, rdata}, {14'h0, word_at(20 + n)}, "drained word");
      n++;
      rfall();
    end
    check_word(32'(n), 32'h0000_0801, "words held");
    set_reader(1'b1, 1'b1);
    repeat (48) @(negedge clk_i);
    check_bit(af_n, 1'b1, "almost full cleared");
    check_bit(space_n, 1'b0, "space returned");
  endtask : test_fall_through
  // Select and enable together: the fallen word is lost, the next one shows
  task automatic test_early_enable;
    push_words(2);
    wait_level(1, 1'b0, 80, "word fell through");
    repeat (40) @(negedge clk_i);
    rfall();
    set_reader(1'b0, 1'b0);
    rfall();
    check_word({14'h0, rdata}, {14'h0, word_at(int'(wr_cnt) - 1)}, "second word");
    set_reader(1'b1, 1'b1);
  endtask : test_early_enable
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    rst_i = 1'b1;
    read_en_n = 1'b1;
    read_select_n = 1'b1;
    retransmit_req_n = 1'b1;
    mark = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wr_target = 32'h0000_0000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check_word({25'h0, rdata_oe, irq, empty_n, valid_n, space_n, ae_n, af_n}, 32'h0000_0009,
      "reset flags");
    test_registers_irq();
    test_standard();
    test_retransmit();
    test_fall_through();
    test_early_enable();
    print_verdict();
  end
endmodule : dual_clock_fifo_flags_retransmit_test
